//--- rtl/mar_pkg.sv
package mar_pkg;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned MAR_CLK_HZ = 100000000;
  localparam int unsigned MAR_TICK_MS = 1000;
  localparam int unsigned MAR_TICK_CYC = (MAR_CLK_HZ / 1000) * MAR_TICK_MS;
  localparam int MAR_TIME_W = 13;
  localparam int MAR_ATT_W = 4;
  localparam int MAR_TRIP_W = 8;
  localparam int MAR_OUT_N = 4;
  localparam logic [MAR_TIME_W-1:0] MAR_DELAY_RST = 13'h0000;
  localparam logic [MAR_ATT_W-1:0] MAR_ATT_RST = 4'h0;
  localparam logic [MAR_TIME_W-1:0] MAR_FREE_RST = 13'h0258;
  localparam logic [MAR_TIME_W-1:0] MAR_FREE_MIN = 13'h0078;

  // ==========================================================================
  // Control modes and output function selects
  // ==========================================================================
  typedef enum logic [1:0] {
    MAR_CTL_TWO = 2'b00,
    MAR_CTL_THREE = 2'b01,
    MAR_CTL_COMMS = 2'b10
  } mar_ctl_t;

  typedef enum logic [1:0] {
    MAR_DO_OFF = 2'b00,
    MAR_DO_PENDING = 2'b01,
    MAR_DO_EXCEEDED = 2'b10,
    MAR_DO_OTHER = 2'b11
  } mar_dosel_t;

  typedef enum logic [2:0] {
    MAR_ST_IDLE = 3'b000,
    MAR_ST_DELAY = 3'b001,
    MAR_ST_RESTART = 3'b010,
    MAR_ST_FREE = 3'b011,
    MAR_ST_EXCEEDED = 3'b100
  } mar_state_t;
endpackage : mar_pkg

//--- rtl/mar_tick.sv
`timescale 1ns/100ps
module mar_tick
  import mar_pkg::*;
#(
  parameter int unsigned TICK_CYC = MAR_TICK_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  output logic tick
);
  // ==========================================================================
  // One-second enable pulse
  // ==========================================================================
  logic [31:0] cnt_reg;
  wire cnt_wrap = (cnt_reg == 32'(TICK_CYC - 1));

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;
      tick <= cnt_wrap;
    end
  end
endmodule : mar_tick

//--- rtl/mar_auto_reset.sv
`timescale 1ns/100ps
// Notes on behaviour
// R1: Enabled auto-reset clears a selected trip itself, then restarts the motor.
// R2: Reset delay and attempt limit come from programmable settings.
// R3: After restart, counters re-arm only after a full trip-free interval.
// R4: Attempts beyond the limit stop the sequence; no more automatic restarts.
// R5: After exceeded, counters re-arm only on user reset or stop.
// R6: With auto-reset on, restart follows expiry of the reset delay.
// R7: Pending and exceeded status routable to any of four digital outputs.
// R8: Sequence works under two-wire, three-wire and comms start control.
// R9: Elapsed delay and attempts are computed retrospectively at power-up; only delay_left is recomputed, attempts_left is kept.
// R10: Two-wire start input must stay asserted; its removal terminates auto-reset.
// R11: Three-wire/comms start state is stored and resumes sequence at power-up.
// R12: Outage longer than delay times attempts terminates the sequence.
// R13: Overload decays after trip; the delay should cover the cooling.
// R14: Remote-start-on-trip trips are ignored while auto-reset is enabled.
// R15: Hand mode overrides auto-reset, ends sequence, re-arms counters.
// R16: Two-wire start rising edge acts as a trip reset.
// R17: Remaining attempts decrement per restart; pending flag during delay.
// R18: Exceeded set on zero remaining plus selected trip; cleared on re-arm.
module mar_auto_reset
  import mar_pkg::*;
#(
  parameter int unsigned TICK_CYC = MAR_TICK_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ar_enable,
  input wire logic [MAR_TIME_W-1:0] reset_delay_s,
  input wire logic [MAR_ATT_W-1:0] reset_attempts,
  input wire logic [MAR_TIME_W-1:0] trip_free_s,
  input wire logic [MAR_TRIP_W-1:0] reset_trip_sel,
  input wire logic [1:0] ctl_mode,
  input wire logic hand_mode,
  input wire logic [MAR_TRIP_W-1:0] trip_in,
  input wire logic remote_start_trip_in,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic user_reset_in,
  input wire logic comms_start,
  input wire logic comms_stop,
  input wire logic powerup,
  input wire logic [15:0] outage_s,
  input wire logic saved_start,
  input wire logic [7:0] dout_sel,
  output logic trip_clear,
  output logic restart_req,
  output logic remote_trip_out,
  output logic start_state,
  output logic ar_pending,
  output logic ar_exceeded,
  output logic [MAR_ATT_W-1:0] attempts_left,
  output logic [MAR_TIME_W-1:0] delay_left,
  output logic [MAR_TIME_W-1:0] free_left,
  output logic [MAR_OUT_N-1:0] dout
);
  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [MAR_TRIP_W+5:0] meta_reg;
  logic [MAR_TRIP_W+5:0] sync_reg;
  logic start_d_reg;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      sync_reg <= '0;
      start_d_reg <= 1'b0;
    end else begin
      meta_reg <= {trip_in, remote_start_trip_in, start_in, stop_in,
                   user_reset_in, comms_start, comms_stop};
      sync_reg <= meta_reg;
      start_d_reg <= sync_reg[4];
    end
  end
  wire [MAR_TRIP_W-1:0] trip_s = sync_reg[MAR_TRIP_W+5:6];
  wire rst_trip_s = sync_reg[5];
  wire start_s = sync_reg[4];
  wire stop_s = sync_reg[3];
  wire ureset_s = sync_reg[2];
  wire cstart_s = sync_reg[1];
  wire cstop_s = sync_reg[0];

  // ==========================================================================
  // Control source decode
  // ==========================================================================
  wire two_wire = (ctl_mode == MAR_CTL_TWO); // R8
  wire comms = (ctl_mode == MAR_CTL_COMMS);
  wire start_rise = two_wire && start_s && !start_d_reg; // R16
  wire stop_cmd = two_wire ? !start_s : (comms ? cstop_s : stop_s); // R10
  wire start_cmd = comms ? cstart_s : start_s;
  wire user_reset = ureset_s || start_rise; // R16
  wire sel_trip = |(trip_s & reset_trip_sel); // R1
  wire rearm = hand_mode || !ar_enable; // R15
  wire [31:0] outage_lim = 32'(reset_delay_s) * 32'(reset_attempts);

  wire tick;
  mar_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .mclk(mclk),
    .rst_b(rst_b),
    .tick(tick)
  );

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  mar_state_t state_reg;
  mar_state_t state_next;
  logic start_mem_reg;
  logic trip_seen_reg;
  // A cleared trip lingers two cycles in the synchroniser; acting on the edge
  // keeps that stale level from re-arming the delay straight after a restart
  wire trip_new = sel_trip && !trip_seen_reg; // R1

  // Start latch: three-wire/comms keep the request across control loss
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      start_mem_reg <= 1'b0;
    end else if (powerup) begin
      start_mem_reg <= two_wire ? start_s : saved_start; // R11
    end else if (stop_cmd) begin
      start_mem_reg <= 1'b0;
    end else if (start_cmd) begin
      start_mem_reg <= 1'b1;
    end
  end
  assign start_state = start_mem_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MAR_ST_IDLE, MAR_ST_FREE: begin
        if (trip_new && start_mem_reg) begin
          state_next = (attempts_left == '0) ? MAR_ST_EXCEEDED : MAR_ST_DELAY; // R4 R18
        end else if (state_reg == MAR_ST_FREE && free_left == '0) begin
          state_next = MAR_ST_IDLE; // R3
        end
      end
      MAR_ST_DELAY: begin
        if (delay_left == '0) begin
          state_next = MAR_ST_RESTART; // R6
        end
      end
      MAR_ST_RESTART: state_next = MAR_ST_FREE;
      MAR_ST_EXCEEDED: begin
        if (user_reset || stop_cmd) begin
          state_next = MAR_ST_IDLE; // R5
        end
      end
      default: state_next = MAR_ST_IDLE;
    endcase
    if (state_reg != MAR_ST_EXCEEDED && (stop_cmd || !start_mem_reg)
        && state_reg != MAR_ST_IDLE) begin
      state_next = MAR_ST_IDLE; // R10
    end
    if (powerup && state_reg == MAR_ST_DELAY && 32'(outage_s) > outage_lim) begin
      state_next = MAR_ST_EXCEEDED; // R12
    end
    if (rearm) begin
      state_next = MAR_ST_IDLE; // R15
    end
  end

  wire to_idle = (state_next == MAR_ST_IDLE) && (state_reg != MAR_ST_IDLE);
  wire enter_delay = (state_next == MAR_ST_DELAY) && (state_reg != MAR_ST_DELAY);
  // Retrospective catch-up: part-delay left over after whole delays in the outage
  wire [15:0] out_rem = (reset_delay_s == '0) ? 16'h0000
                      : 16'(outage_s % 16'(reset_delay_s)); // R9

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= MAR_ST_IDLE;
      attempts_left <= MAR_ATT_RST;
      delay_left <= MAR_DELAY_RST;
      free_left <= MAR_FREE_RST;
      trip_clear <= 1'b0;
      restart_req <= 1'b0;
      trip_seen_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      trip_clear <= (state_next == MAR_ST_RESTART); // R1
      restart_req <= (state_next == MAR_ST_RESTART); // R6
      trip_seen_reg <= sel_trip;
      if (to_idle && state_reg != MAR_ST_FREE || state_reg == MAR_ST_IDLE
          && !sel_trip || (state_reg == MAR_ST_FREE && free_left == '0)) begin
        attempts_left <= reset_attempts; // R2 R3 R5
        delay_left <= reset_delay_s;
      end else if (enter_delay) begin
        delay_left <= reset_delay_s; // R2 R13
      end else if (powerup && state_reg == MAR_ST_DELAY) begin
        delay_left <= (16'(delay_left) > out_rem) ? delay_left - MAR_TIME_W'(out_rem)
                    : '0; // R9
      end else if (state_reg == MAR_ST_DELAY && tick && delay_left != '0) begin
        delay_left <= delay_left - 13'h0001;
      end
      if (state_next == MAR_ST_RESTART && attempts_left != '0) begin
        attempts_left <= attempts_left - 4'h1; // R17
      end
      if (state_next == MAR_ST_FREE && state_reg != MAR_ST_FREE) begin
        free_left <= (trip_free_s < MAR_FREE_MIN) ? MAR_FREE_MIN : trip_free_s; // R3
      end else if (state_reg == MAR_ST_FREE && tick && free_left != '0) begin
        free_left <= free_left - 13'h0001;
      end
    end
  end

  // ==========================================================================
  // Status and digital output routing
  // ==========================================================================
  assign ar_pending = (state_reg == MAR_ST_DELAY); // R17
  assign ar_exceeded = (state_reg == MAR_ST_EXCEEDED); // R18
  assign remote_trip_out = rst_trip_s && !ar_enable; // R14

  logic [MAR_OUT_N-1:0] dout_next;
  always_comb begin
    for (int i = 0; i < MAR_OUT_N; i++) begin
      case (mar_dosel_t'(dout_sel[2*i +: 2]))
        MAR_DO_PENDING: dout_next[i] = ar_pending; // R7
        MAR_DO_EXCEEDED: dout_next[i] = ar_exceeded; // R7
        default: dout_next[i] = 1'b0;
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dout <= '0;
    end else begin
      dout <= dout_next;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  property p_pend;
    @(posedge mclk) disable iff (!rst_b) ar_pending && delay_left == '0 && !rearm
      && !stop_cmd && start_mem_reg && !powerup |=> restart_req;
  endproperty
  a_pend: assert property (p_pend) else $error("restart not issued"); // R6

  property p_hand;
    @(posedge mclk) disable iff (!rst_b) hand_mode |=> state_reg == MAR_ST_IDLE;
  endproperty
  a_hand: assert property (p_hand) else $error("hand mode not honoured"); // R15

  property p_exc;
    @(posedge mclk) disable iff (!rst_b) ar_exceeded && !user_reset && !stop_cmd
      && !rearm |=> ar_exceeded;
  endproperty
  a_exc: assert property (p_exc) else $error("exceeded released early"); // R5

  property p_noexc_restart;
    @(posedge mclk) disable iff (!rst_b) ar_exceeded |-> !restart_req;
  endproperty
  a_noexc_restart: assert property (p_noexc_restart) else $error("restart after limit"); // R4

  property p_exc_zero;
    @(posedge mclk) disable iff (!rst_b) $rose(ar_exceeded) && !$past(powerup)
      |-> $past(attempts_left) == '0;
  endproperty
  a_exc_zero: assert property (p_exc_zero) else $error("exceeded with attempts left"); // R18

  property p_remote;
    @(posedge mclk) disable iff (!rst_b) ar_enable |-> !remote_trip_out;
  endproperty
  a_remote: assert property (p_remote) else $error("remote trip passed"); // R14

  property p_dec;
    @(posedge mclk) disable iff (!rst_b) restart_req && $past(attempts_left) != '0
      |-> attempts_left == $past(attempts_left) - 4'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("attempts not decremented"); // R17

  sequence s_restart;
    restart_req ##1 state_reg == MAR_ST_FREE;
  endsequence
  property p_free;
    @(posedge mclk) disable iff (!rst_b) s_restart |-> free_left >= MAR_FREE_MIN;
  endproperty
  a_free: assert property (p_free) else $error("trip-free time short"); // R3

  property p_clear;
    @(posedge mclk) disable iff (!rst_b) restart_req |-> trip_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("trip not cleared"); // R1
endmodule : mar_auto_reset

//--- dv/mar_far_model.sv
`timescale 1ns/100ps
module mar_far_model
  import mar_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [MAR_TRIP_W-1:0] fault_set,
  input wire logic trip_clear,
  input wire logic user_reset_in,
  output logic [MAR_TRIP_W-1:0] trip_in
);
  // ==========================================================================
  // Trip sources
  // ==========================================================================
  // A protection trip stays latched until the starter or the user clears it,
  // so a missing clear shows up as a repeated or stuck trip
  always_ff @(posedge mclk) begin
    if (!rst_b || trip_clear || user_reset_in) begin
      trip_in <= '0;
    end else begin
      trip_in <= trip_in | fault_set;
    end
  end
endmodule : mar_far_model

//--- dv/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import mar_pkg::*;
;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic mclk, rst_b, ar_enable, hand_mode, remote_start_trip_in, start_in, stop_in;
  logic user_reset_in, comms_start, comms_stop, powerup, saved_start;
  logic [MAR_TIME_W-1:0] reset_delay_s, trip_free_s, delay_left, free_left;
  logic [MAR_ATT_W-1:0] reset_attempts, attempts_left;
  logic [MAR_TRIP_W-1:0] reset_trip_sel, trip_in, fault_set;
  logic [1:0] ctl_mode;
  logic [15:0] outage_s;
  logic [7:0] dout_sel;
  logic trip_clear, restart_req, remote_trip_out, start_state, ar_pending, ar_exceeded;
  logic [MAR_OUT_N-1:0] dout;
  int n_mismatch = 0;
  int n_checks = 0;

  mar_auto_reset #(.TICK_CYC(10)) mar_auto_reset_i (.mclk(mclk), .rst_b(rst_b),
    .ar_enable(ar_enable), .reset_delay_s(reset_delay_s), .reset_attempts(reset_attempts),
    .trip_free_s(trip_free_s), .reset_trip_sel(reset_trip_sel), .ctl_mode(ctl_mode),
    .hand_mode(hand_mode), .trip_in(trip_in), .remote_start_trip_in(remote_start_trip_in),
    .start_in(start_in), .stop_in(stop_in), .user_reset_in(user_reset_in),
    .comms_start(comms_start), .comms_stop(comms_stop), .powerup(powerup),
    .outage_s(outage_s), .saved_start(saved_start), .dout_sel(dout_sel),
    .trip_clear(trip_clear), .restart_req(restart_req), .remote_trip_out(remote_trip_out),
    .start_state(start_state), .ar_pending(ar_pending), .ar_exceeded(ar_exceeded),
    .attempts_left(attempts_left), .delay_left(delay_left), .free_left(free_left),
    .dout(dout));

  mar_far_model mar_far_model_i (.mclk(mclk), .rst_b(rst_b), .fault_set(fault_set),
    .trip_clear(trip_clear), .user_reset_in(user_reset_in), .trip_in(trip_in));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Momentary command: 0 user reset, 1 comms start, 2 comms stop, 3 stop input
  task automatic pulse(input int sel);
    case (sel)
      0: user_reset_in <= 1'b1;
      1: comms_start <= 1'b1;
      2: comms_stop <= 1'b1;
      default: stop_in <= 1'b1;
    endcase
    cyc(3);
    user_reset_in <= 1'b0;
    comms_start <= 1'b0;
    comms_stop <= 1'b0;
    stop_in <= 1'b0;
    cyc(6);
  endtask : pulse

  task automatic fault(input logic [7:0] b);
    fault_set <= b;
    cyc(1);
    fault_set <= '0;
    cyc(8);
  endtask : fault

  // Stops after 80 cycles, longer than a 2 s delay at the short tick
  task automatic wait_rst(output int n);
    n = 0;
    while (restart_req !== 1'b1 && n < 80) begin
      cyc(1);
      n++;
    end
  endtask : wait_rst

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_restart(input logic [3:0] left);
    int n;
    fault(8'h01);
    chk(ar_pending, 1'b1);
    chk(dout, 4'h1);
    chk(delay_left != '0 && delay_left <= reset_delay_s, 1'b1);
    wait_rst(n);
    chk(trip_clear, 1'b1);
    chk(n >= 5 && n < 80, 1'b1);
    cyc(2);
    chk(ar_pending, 1'b0);
    chk(attempts_left, left);
    chk(free_left > (MAR_FREE_MIN - 13'h0002) && free_left <= MAR_FREE_MIN, 1'b1);
  endtask : t_restart

  task automatic t_exceed;
    int n;
    t_restart(4'h0);
    fault(8'h01);
    chk(ar_exceeded, 1'b1);
    chk(dout, 4'h2);
    wait_rst(n);
    chk(restart_req, 1'b0);
    pulse(0);
    chk(ar_exceeded, 1'b0);
    chk(attempts_left, 4'h2);
  endtask : t_exceed

  task automatic t_rearm;
    trip_free_s <= 13'h0010;
    t_restart(4'h1);
    cyc(600);
    chk(attempts_left, 4'h1);
    cyc(700);
    chk(attempts_left, 4'h2);
  endtask : t_rearm

  task automatic t_unsel_hand;
    fault(8'h02);
    chk(ar_pending, 1'b0);
    pulse(0);
    fault(8'h01);
    hand_mode <= 1'b1;
    cyc(4);
    chk(ar_pending, 1'b0);
    chk(attempts_left, 4'h2);
    pulse(0);
    hand_mode <= 1'b0;
    cyc(4);
  endtask : t_unsel_hand

  task automatic t_remote;
    remote_start_trip_in <= 1'b1;
    cyc(4);
    chk(remote_trip_out, 1'b0);
    ar_enable <= 1'b0;
    cyc(4);
    chk(remote_trip_out, 1'b1);
    remote_start_trip_in <= 1'b0;
    ar_enable <= 1'b1;
    cyc(6);
  endtask : t_remote

  task automatic t_comms_outage;
    ctl_mode <= 2'b10;
    pulse(1);
    t_restart(4'h1);
    fault(8'h01);
    outage_s <= 16'h0064;
    powerup <= 1'b1;
    cyc(1);
    powerup <= 1'b0;
    cyc(3);
    chk(ar_exceeded, 1'b1);
    pulse(2);
    chk(ar_exceeded, 1'b0);
    pulse(0);
  endtask : t_comms_outage

  // Momentary start, then a short outage inside the delay with the stored start set
  task automatic t_three_wire;
    int n;
    ctl_mode <= 2'b01;
    reset_delay_s <= 13'h0005;
    cyc(4);
    chk(start_state, 1'b1);
    start_in <= 1'b0;
    fault(8'h01);
    chk(ar_pending, 1'b1);
    saved_start <= 1'b1;
    outage_s <= 16'h0003;
    powerup <= 1'b1;
    cyc(1);
    powerup <= 1'b0;
    cyc(1);
    chk(delay_left != '0 && delay_left <= 13'h0002, 1'b1);
    chk(start_state, 1'b1);
    chk(ar_pending, 1'b1);
    wait_rst(n);
    chk(restart_req, 1'b1);
    cyc(4);
    pulse(3);
    chk(start_state, 1'b0);
    chk(ar_pending | ar_exceeded, 1'b0);
  endtask : t_three_wire

  // ==========================================================================
  // Run control
  // ==========================================================================
  task automatic finish_test;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    cyc(20000);
    n_mismatch++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    ar_enable = 1'b1;
    reset_delay_s = 13'h0002;
    reset_attempts = 4'h2;
    trip_free_s = 13'h0078;
    reset_trip_sel = 8'h01;
    ctl_mode = 2'b00;
    hand_mode = 1'b0;
    remote_start_trip_in = 1'b0;
    start_in = 1'b1;
    stop_in = 1'b0;
    user_reset_in = 1'b0;
    comms_start = 1'b0;
    comms_stop = 1'b0;
    powerup = 1'b0;
    outage_s = 16'h0000;
    saved_start = 1'b0;
    dout_sel = 8'h09;
    fault_set = 8'h00;
    cyc(12);
    rst_b <= 1'b1;
    cyc(6);
    chk(attempts_left, 4'h2);
    t_restart(4'h1);
    t_exceed();
    t_rearm();
    t_unsel_hand();
    t_remote();
    t_comms_outage();
    t_three_wire();
    finish_test();
  end
endmodule : tb_top
